//--- hw/dcs_regs.svh
// constants of the digital i/o command server: codes, limits, counts
// assumes a byte stream from a tcp stack that tags each packet's port
`ifndef DCS_REGS_SVH
`define DCS_REGS_SVH

// ==========================================================
// packet layout
`define DCS_HDR_BYTES 9'h004
`define DCS_DATA_MAX 9'h012
`define DCS_VERSION 8'h02
`define DCS_LISTEN_PORT 16'h1389

// ==========================================================
// command codes
`define DCS_CMD_RD_ONE 8'h01
`define DCS_CMD_WR_ONE 8'h02
`define DCS_CMD_RD_RANGE 8'h05
`define DCS_CMD_WR_RANGE 8'h06

// ==========================================================
// completion codes
`define DCS_ST_OK 8'h00
`define DCS_ST_CMD_ERR 8'h01
`define DCS_ST_VER_ERR 8'h02
`define DCS_ST_LEN_ERR 8'h03
`define DCS_ST_OP_ERR 8'h04
`define DCS_ST_SHORT 8'h05
`define DCS_ST_LINE_ERR 8'h06
`define DCS_ST_OTHER 8'hff

// ==========================================================
// digital_io_line count
`define DCS_NLINES 8'h08

`endif

//--- hw/dcs_pkg.sv
// types shared by the digital i/o command server
// assumes dcs_regs.svh for the numeric constants
package dcs_pkg;

    // ======================================================
    // stream carriers
    typedef struct packed {
        logic [15:0] port;
        logic [7:0] data;
        logic last;
    } dcs_rx_t;

    typedef struct packed {
        logic [7:0] data;
        logic last;
    } dcs_tx_t;

    // ======================================================
    // sequencer and state
    typedef enum logic [1:0] {
        DCS_RECV,
        DCS_DROP,
        DCS_EXEC,
        DCS_SEND
    } dcs_state_t;

    typedef struct packed {
        dcs_state_t st;
        logic [8:0] cnt;
        logic [7:0] cmd;
        logic [7:0] ver;
        logic [7:0] len;
        logic [17:0][7:0] dat;
        logic [7:0] stat;
        logic [7:0] rlen;
        logic [8:0] tix;
        logic [7:0] dir;
        logic [7:0] lvl;
        logic [7:0] in_s1;
        logic [7:0] in_s2;
        logic [7:0] tx_byte;
        logic tx_valid;
        logic tx_last;
    } dcs_regs_t;

endpackage

//--- hw/dcs_server.sv
// digital i/o command server: parses command packets, drives the
// digital_io_line pins and answers each packet for its port with an acknowledge.
// assumes a tcp stack delivering packets as byte streams with a last
// flag and the destination port, and taking the reply the same way.
//
// How it works
// - command is four-byte header plus data
// - every command on port 5001 gets header plus data reply
// - header is code, version, status, length
// - code byte selects operation, 1 reads
// - status 0 for success, error code 1 to 6 otherwise
// - unknown command code answers status 1
// - wrong version answers status 2
// - length mismatch 3, too short 5
// - input mode with level set gives 4
// - line number 8 or above, or a range with first above last, answers status 6
// - only packets for port 5001 accepted
// - read one: line, direction, level back
// - code 2 writes one line, echoes state
// - code 5 reads range as byte pairs
// - code 6 writes range, returns pairs
`timescale 1ns/1ns
`include "dcs_regs.svh"

module dcs_server (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    // command stream from the network stack
    input wire logic rx_valid_in,
    input wire dcs_pkg::dcs_rx_t rx_in,
    output logic rx_ready_out,
    // acknowledge stream to the network stack
    output logic tx_valid_out,
    output dcs_pkg::dcs_tx_t tx_out,
    input wire logic tx_ready_in,
    // digital_io_line pins
    input wire logic [7:0] dio_in,
    output logic [7:0] dio_out,
    output logic [7:0] dio_oe_out
);

    // ======================================================
    // helpers
    // picks the bit of a line vector for a line number
    function automatic logic dcs_bit(input logic [7:0] v,
                                     input logic [7:0] n);
        dcs_bit = v[n[2:0]];
    endfunction

    // level seen on a line: driven value or synchronised pin
    function automatic logic dcs_level(input dcs_pkg::dcs_regs_t r,
                                       input logic [7:0] n);
        dcs_level = dcs_bit(r.dir, n) ? dcs_bit(r.lvl, n)
                                      : dcs_bit(r.in_s2, n);
    endfunction

    // ======================================================
    // state
    dcs_pkg::dcs_regs_t q;
    dcs_pkg::dcs_regs_t d;

    // ======================================================
    // next state
    always_comb begin
        logic [8:0] dcnt;
        logic [7:0] first;
        logic [7:0] lastl;
        logic [8:0] span;
        logic [9:0] need;
        logic [7:0] st;
        logic [8:0] di;
        logic [7:0] line;
        logic [7:0] ob;
        logic rng_ok;
        int idx;
        d = q;
        dcnt = q.cnt - `DCS_HDR_BYTES;
        first = q.dat[0];
        lastl = q.dat[1];
        span = {1'b0, lastl} - {1'b0, first} + 9'h001;
        need = {span, 1'b0} + 10'h002;
        st = `DCS_ST_OK;
        di = q.tix - `DCS_HDR_BYTES;
        line = 8'h00;
        ob = 8'h00;
        idx = 0;
        rng_ok = (first < `DCS_NLINES) && (lastl < `DCS_NLINES)
                 && (first <= lastl);
        // pin synchroniser, first stage read only by the second
        d.in_s1 = dio_in;
        d.in_s2 = q.in_s1;
        unique case (q.st)
            dcs_pkg::DCS_RECV: begin
                if (rx_valid_in) begin
                    if (q.cnt == 9'h000 &&
                        rx_in.port != `DCS_LISTEN_PORT) begin
                        // foreign port: swallow the packet unanswered
                        d.st = rx_in.last ? dcs_pkg::DCS_RECV
                                          : dcs_pkg::DCS_DROP;
                    end else begin
                        // header fields in fixed order
                        if (q.cnt == 9'h000) d.cmd = rx_in.data;
                        if (q.cnt == 9'h001) d.ver = rx_in.data;
                        if (q.cnt == 9'h003) d.len = rx_in.data;
                        // data past the longest legal packet is only
                        // counted, which is enough to flag a bad length
                        if (q.cnt >= `DCS_HDR_BYTES &&
                            dcnt < `DCS_DATA_MAX) begin
                            d.dat[dcnt[4:0]] = rx_in.data;
                        end
                        if (q.cnt != 9'h1ff) d.cnt = q.cnt + 9'h001;
                        if (rx_in.last) d.st = dcs_pkg::DCS_EXEC;
                    end
                end
            end
            dcs_pkg::DCS_DROP: begin
                if (rx_valid_in && rx_in.last) d.st = dcs_pkg::DCS_RECV;
            end
            dcs_pkg::DCS_EXEC: begin
                // checks in priority order: shape, version, length,
                // then command-specific checks
                if (q.cnt < `DCS_HDR_BYTES) begin
                    st = `DCS_ST_SHORT;
                end else if (q.ver != `DCS_VERSION) begin
                    st = `DCS_ST_VER_ERR;
                end else if ({1'b0, q.len} != dcnt || q.len == 8'h00) begin
                    st = `DCS_ST_LEN_ERR;
                end else begin
                    unique case (q.cmd)
                        `DCS_CMD_RD_ONE: begin
                            if (q.len != 8'h01) st = `DCS_ST_LEN_ERR;
                            else if (first >= `DCS_NLINES)
                                st = `DCS_ST_LINE_ERR;
                        end
                        `DCS_CMD_WR_ONE: begin
                            if (q.len != 8'h03) st = `DCS_ST_LEN_ERR;
                            else if (first >= `DCS_NLINES)
                                st = `DCS_ST_LINE_ERR;
                            else if (q.dat[1] == 8'h00 && q.dat[2] != 8'h00)
                                st = `DCS_ST_OP_ERR;
                        end
                        `DCS_CMD_RD_RANGE: begin
                            if (q.len != 8'h02) st = `DCS_ST_LEN_ERR;
                            else if (!rng_ok) st = `DCS_ST_LINE_ERR;
                        end
                        `DCS_CMD_WR_RANGE: begin
                            if (q.len < 8'h02) st = `DCS_ST_LEN_ERR;
                            else if (!rng_ok) st = `DCS_ST_LINE_ERR;
                            else if ({2'b00, q.len} != need)
                                st = `DCS_ST_LEN_ERR;
                            else begin
                                for (int i = 0; i < 8; i++) begin
                                    idx = (i - int'(first)) * 2 + 2;
                                    if (i >= int'(first) && i <= int'(lastl)
                                        && q.dat[idx] == 8'h00
                                        && q.dat[idx + 1] != 8'h00)
                                        st = `DCS_ST_OP_ERR;
                                end
                            end
                        end
                        default: st = `DCS_ST_CMD_ERR;
                    endcase
                end
                // lines change only on success
                if (st == `DCS_ST_OK) begin
                    if (q.cmd == `DCS_CMD_WR_ONE) begin
                        d.dir[first[2:0]] = q.dat[1] != 8'h00;
                        d.lvl[first[2:0]] = q.dat[2] != 8'h00;
                    end
                    if (q.cmd == `DCS_CMD_WR_RANGE) begin
                        for (int i = 0; i < 8; i++) begin
                            idx = (i - int'(first)) * 2 + 2;
                            if (i >= int'(first) && i <= int'(lastl)) begin
                                d.dir[i] = q.dat[idx] != 8'h00;
                                d.lvl[i] = q.dat[idx + 1] != 8'h00;
                            end
                        end
                    end
                end
                d.stat = st;
                if (st != `DCS_ST_OK) d.rlen = 8'h01;
                else if (q.cmd == `DCS_CMD_RD_ONE ||
                         q.cmd == `DCS_CMD_WR_ONE) d.rlen = 8'h03;
                else d.rlen = {span[6:0], 1'b0};
                d.tix = 9'h000;
                d.st = dcs_pkg::DCS_SEND;
            end
            dcs_pkg::DCS_SEND: begin
                // reply data reflects state after any write
                if (q.cmd == `DCS_CMD_RD_ONE || q.cmd == `DCS_CMD_WR_ONE)
                    line = first;
                else
                    line = first + {1'b0, di[7:1]};
                if (q.stat != `DCS_ST_OK) ob = 8'h00;
                else if (q.cmd == `DCS_CMD_RD_ONE ||
                         q.cmd == `DCS_CMD_WR_ONE) begin
                    if (di == 9'h000) ob = first;
                    else if (di == 9'h001)
                        ob = {7'h00, dcs_bit(q.dir, line)};
                    else ob = {7'h00, dcs_level(q, line)};
                end else if (!di[0]) ob = {7'h00, dcs_bit(q.dir, line)};
                else ob = {7'h00, dcs_level(q, line)};
                // output slot frees when the stack takes the byte
                if (!q.tx_valid || tx_ready_in) begin
                    d.tx_valid = 1'b0;
                    if (q.tix <= {1'b0, q.rlen} + 9'h003) begin
                        unique case (q.tix)
                            9'h000: d.tx_byte = q.cmd;
                            9'h001: d.tx_byte = q.ver;
                            9'h002: d.tx_byte = q.stat;
                            9'h003: d.tx_byte = q.rlen;
                            default: d.tx_byte = ob;
                        endcase
                        d.tx_valid = 1'b1;
                        d.tx_last = q.tix == {1'b0, q.rlen} + 9'h003;
                        d.tix = q.tix + 9'h001;
                    end else begin
                        // last byte accepted: ready for next packet
                        d.st = dcs_pkg::DCS_RECV;
                        d.cnt = 9'h000;
                    end
                end
            end
        endcase
    end

    // ======================================================
    // registers, synchronous active-low reset
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ======================================================
    // outputs
    assign rx_ready_out = (q.st == dcs_pkg::DCS_RECV) ||
                          (q.st == dcs_pkg::DCS_DROP);
    assign tx_valid_out = q.tx_valid;
    assign tx_out = '{data: q.tx_byte, last: q.tx_last};
    assign dio_out = q.lvl;
    assign dio_oe_out = q.dir; // high where line is an output

endmodule

//--- bench/dcs_server_chk.sv
// port checker for the digital i/o command server
// assumes the dcs_server port list; bound after the module
`timescale 1ns/1ns
`include "dcs_regs.svh"
module dcs_server_chk (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    // command stream
    input wire logic rx_valid_in,
    input wire dcs_pkg::dcs_rx_t rx_in,
    input wire logic rx_ready_out,
    // reply stream
    input wire logic tx_valid_out,
    input wire dcs_pkg::dcs_tx_t tx_out,
    input wire logic tx_ready_in,
    // line pins
    input wire logic [7:0] dio_in,
    input wire logic [7:0] dio_out,
    input wire logic [7:0] dio_oe_out
);
    // ==========================================================
    // packet tracking
    logic first_q;
    logic ok_q;
    logic [7:0] cmd_q;
    logic [7:0] tix_q;
    logic ok_now;
    // port is only valid on a packet's first byte
    assign ok_now = first_q ? (rx_in.port == `DCS_LISTEN_PORT) : ok_q;
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            first_q <= 1'b1;
            ok_q <= 1'b0;
            cmd_q <= 8'h00;
            tix_q <= 8'h00;
        end else begin
            if (rx_valid_in && rx_ready_out) begin
                first_q <= rx_in.last;
                ok_q <= ok_now;
                if (first_q) cmd_q <= rx_in.data;
            end
            if (tx_valid_out && tx_ready_in) begin
                tix_q <= tx_out.last ? 8'h00 : tix_q + 8'h01;
            end
        end
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);
    // ==========================================================
    // properties
    sequence s_take_last;
        rx_valid_in && rx_ready_out && rx_in.last;
    endsequence
    sequence s_take_tail;
        tx_valid_out && tx_ready_in && tx_out.last;
    endsequence
    property p_reply;
        // exec cycle, then load cycle: first byte seen on the third edge
        s_take_last and ok_now |=> !rx_ready_out [*2] ##1 tx_valid_out;
    endproperty
    property p_drop;
        s_take_last and !ok_now |=> !tx_valid_out [*4];
    endproperty
    property p_hold;
        tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_out);
    endproperty
    property p_tail;
        s_take_tail |=> !tx_valid_out ##1 rx_ready_out;
    endproperty
    property p_excl;
        tx_valid_out |-> !rx_ready_out;
    endproperty
    property p_echo;
        $rose(tx_valid_out) |-> tx_out.data == cmd_q;
    endproperty
    property p_pins;
        !$stable(dio_oe_out) || !$stable(dio_out) |-> !rx_ready_out;
    endproperty
    property p_min;
        s_take_tail |-> tix_q >= 8'h04;
    endproperty
    a_reply: assert property (p_reply)
        else $error("no reply three cycles after packet end");
    a_drop: assert property (p_drop)
        else $error("reply to a packet for another port");
    a_hold: assert property (p_hold)
        else $error("reply byte changed before taken");
    a_tail: assert property (p_tail)
        else $error("reply end not followed by idle and ready");
    a_excl: assert property (p_excl)
        else $error("command taken while replying");
    a_echo: assert property (p_echo)
        else $error("reply does not start with command code");
    a_pins: assert property (p_pins)
        else $error("line state changed while receiving");
    a_min: assert property (p_min)
        else $error("reply shorter than header plus one byte");
endmodule

bind dcs_server dcs_server_chk chk_u (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .rx_valid_in(rx_valid_in),
    .rx_in(rx_in),
    .rx_ready_out(rx_ready_out),
    .tx_valid_out(tx_valid_out),
    .tx_out(tx_out),
    .tx_ready_in(tx_ready_in),
    .dio_in(dio_in),
    .dio_out(dio_out),
    .dio_oe_out(dio_oe_out)
);

//--- bench/dcs_host_model.sv
// host side model: sends one command packet, collects the reply
// assumes the server's valid/ready byte streams on one clock
`timescale 1ns/1ns
module dcs_host_model (
    // clock
    input wire logic clk_sys_in,
    // command stream
    output logic rx_valid_in,
    output dcs_pkg::dcs_rx_t rx_in,
    input wire logic rx_ready_out,
    // reply stream
    input wire logic tx_valid_out,
    input wire dcs_pkg::dcs_tx_t tx_out,
    output logic tx_ready_in
);
    // ==========================================================
    // packet transfer
    initial begin
        rx_valid_in = 1'b0;
        rx_in = '0;
        tx_ready_in = 1'b0;
    end
    // slow mode drops ready on every other cycle of the reply
    task automatic xfer(input logic [15:0] prt, input logic [7:0] b[$],
                        input bit slow, output logic [7:0] r[$]);
        int i;
        int n;
        logic rdy;
        logic v;
        dcs_pkg::dcs_tx_t t;
        r = {};
        for (i = 0; i < b.size(); i++) begin
            rx_valid_in = 1'b1;
            rx_in = '{prt, b[i], i == b.size() - 1};
            do begin
                rdy = rx_ready_out;
                @(posedge clk_sys_in);
                #1;
            end while (!rdy);
        end
        rx_valid_in = 1'b0;
        rx_in.data = ~rx_in.data; // released byte must not look valid
        n = 0;
        while (prt == 16'h1389 && n < 300) begin
            tx_ready_in = slow ? n[0] : 1'b1;
            v = tx_valid_out && tx_ready_in;
            t = tx_out;
            @(posedge clk_sys_in);
            #1;
            n++;
            if (v) r.push_back(t.data);
            if (v && t.last) break;
        end
        tx_ready_in = 1'b0;
    endtask
endmodule

//--- bench/dcs_server_tb.sv
// self-checking bench for the digital i/o command server
// assumes dcs_host_model as the network side
`timescale 1ns/1ns
module dcs_server_tb;
    logic clk_sys_in, rst_b_in, rx_valid_in, rx_ready_out;
    logic tx_valid_out, tx_ready_in;
    dcs_pkg::dcs_rx_t rx_in;
    dcs_pkg::dcs_tx_t tx_out;
    logic [7:0] dio_in, dio_out, dio_oe_out;
    int n_fail, n_checks;
    localparam logic [15:0] P = 16'h1389;
    dcs_server dut_u (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
        .rx_valid_in(rx_valid_in), .rx_in(rx_in),
        .rx_ready_out(rx_ready_out), .tx_valid_out(tx_valid_out),
        .tx_out(tx_out), .tx_ready_in(tx_ready_in), .dio_in(dio_in),
        .dio_out(dio_out), .dio_oe_out(dio_oe_out));
    dcs_host_model host_u (.clk_sys_in(clk_sys_in),
        .rx_valid_in(rx_valid_in), .rx_in(rx_in),
        .rx_ready_out(rx_ready_out), .tx_valid_out(tx_valid_out),
        .tx_out(tx_out), .tx_ready_in(tx_ready_in));
    // ==========================================================
    // clock, compare and reply helpers
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic run(input logic [7:0] b[$], input bit slow,
                       input logic [7:0] e[$]);
        logic [7:0] r[$];
        host_u.xfer(P, b, slow, r);
        check(r.size(), e.size());
        foreach (e[i]) check(r[i], e[i]);
    endtask
    // error reply: code and version echoed, one zero data byte
    task automatic err(input logic [7:0] b[$], input logic [7:0] st);
        run(b, 1'b0, {b[0], b[1], st, 8'h01, 8'h00});
        check({dio_oe_out, dio_out}, 16'h0b09);
    endtask
    task automatic close_out;
        if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ==========================================================
    // scenarios
    task automatic t_single;
        run({8'h02, 8'h02, 8'h00, 8'h03, 8'h03, 8'h01, 8'h01}, 1'b0,
            {8'h02, 8'h02, 8'h00, 8'h03, 8'h03, 8'h01, 8'h01});
        check({dio_oe_out[3], dio_out[3]}, 2'b11);
        run({8'h01, 8'h02, 8'h00, 8'h01, 8'h03}, 1'b1,
            {8'h01, 8'h02, 8'h00, 8'h03, 8'h03, 8'h01, 8'h01});
        run({8'h01, 8'h02, 8'h00, 8'h01, 8'h05}, 1'b0,
            {8'h01, 8'h02, 8'h00, 8'h03, 8'h05, 8'h00, 8'h01});
    endtask
    task automatic t_range;
        run({8'h06, 8'h02, 8'h00, 8'h06, 8'h00, 8'h01, 8'h01, 8'h01, 8'h01,
             8'h00}, 1'b0, {8'h06, 8'h02, 8'h00, 8'h04, 8'h01, 8'h01, 8'h01,
             8'h00});
        check({dio_oe_out[1:0], dio_out[1:0]}, 4'b1101);
        run({8'h05, 8'h02, 8'h00, 8'h02, 8'h02, 8'h03}, 1'b1,
            {8'h05, 8'h02, 8'h00, 8'h04, 8'h00, 8'h00, 8'h01, 8'h01});
    endtask
    task automatic t_errors;
        err({8'h07, 8'h02, 8'h00, 8'h01, 8'h00}, 8'h01);
        err({8'h01, 8'h03, 8'h00, 8'h01, 8'h00}, 8'h02);
        err({8'h01, 8'h02, 8'h00, 8'h02, 8'h00}, 8'h03);
        err({8'h01, 8'h02}, 8'h05);
        err({8'h02, 8'h02, 8'h00, 8'h03, 8'h04, 8'h00, 8'h01}, 8'h04);
        err({8'h01, 8'h02, 8'h00, 8'h01, 8'h08}, 8'h06);
        err({8'h05, 8'h02, 8'h00, 8'h02, 8'h03, 8'h02}, 8'h06);
        err({8'h06, 8'h02, 8'h00, 8'h04, 8'h04, 8'h04, 8'h00, 8'h01},
            8'h04);
        err({8'h06, 8'h02, 8'h00, 8'h04, 8'h04, 8'h05, 8'h01, 8'h01},
            8'h03);
    endtask
    task automatic t_port;
        logic [7:0] r[$];
        host_u.xfer(16'h1388, {8'h01, 8'h02, 8'h00, 8'h01, 8'h03}, 1'b0, r);
        repeat (10) begin
            check(tx_valid_out, 1'b0);
            @(posedge clk_sys_in);
            #1;
        end
        run({8'h01, 8'h02, 8'h00, 8'h01, 8'h00}, 1'b0,
            {8'h01, 8'h02, 8'h00, 8'h03, 8'h00, 8'h01, 8'h01});
    endtask
    // ==========================================================
    // main sequence and watchdog
    initial begin
        n_fail = 0;
        n_checks = 0;
        rst_b_in = 1'b0;
        dio_in = 8'h20; // line 5 high, line 2 low as inputs
        repeat (8) @(posedge clk_sys_in);
        #1;
        rst_b_in = 1'b1;
        check({rx_ready_out, tx_valid_out, dio_oe_out}, 10'h200);
        t_single();
        t_range();
        t_errors();
        t_port();
        close_out();
    end
    // a hang costs at most 20000 cycles, far above the run's length
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        n_fail++;
        close_out();
    end
endmodule
